// ===== rtl/apsf_pkg.sv
// Purpose: Shared constants for the audio path select and filter chain
// Assumes: 200 MHz clock, 16-bit two's-complement samples
// Notes: Coefficients are signed fixed point with 13 fraction bits
package apsf_pkg;
    // ********
    // Widths and fixed-point format
    // ********
    localparam int SAMPLE_W = 16;
    localparam int COEF_W = 14;
    localparam int COEF_FRAC = 13;
    localparam int PAIR_W = 2 * SAMPLE_W;
    localparam int FIFO_DEPTH = 16;
    localparam int NUM_STAGES = 4;

    // ********
    // Stage order through the chain
    // ********
    localparam int STG_HP1 = 0;
    localparam int STG_HP2 = 1;
    localparam int STG_LP = 2;
    localparam int STG_SEP = 3;

    // ********
    // Timing: sample rate derived from the system clock
    // ********
    localparam longint CLOCK_HZ = 200_000_000;
    localparam longint SAMPLE_HZ = 44_100;
    localparam int FS_DIV = int'(CLOCK_HZ / SAMPLE_HZ);

    // ********
    // Reset values and saturation limits
    // ********
    localparam logic [15:0] SAMPLE_ZERO = 16'h0000;
    localparam logic [15:0] SAMPLE_MAX = 16'h7fff;
    localparam logic [15:0] SAMPLE_MIN = 16'h8000;

    typedef enum {
        APSF_IDLE,
        APSF_RUN,
        APSF_EMIT
    } apsf_state_t;
endpackage

// ===== rtl/apsf_fifo.sv
// Purpose: Sample-pair FIFO between the source mux and the filter chain
// Assumes: Single clock, DEPTH a power of two
// Notes: Ready and valid are flops computed from the next fill level
`timescale 1ns/1ps
module apsf_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    // ********
    // Handshakes
    // ********
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rd_ptr];

    // Fill level after this cycle's push and pop
    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    // Storage has no reset; only the pointers, level and flags need one
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers, level and flags
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= next_count;
            in_ready <= (next_count != (AW+1)'(DEPTH));
            out_valid <= (next_count != '0);
        end
    end
endmodule

// ===== rtl/apsf_chain.sv
// Purpose: Path select, shared filter chain and mic supply control
// Assumes: Host keeps enables low on mode and coefficient changes
// Notes: One stereo pair per sample tick; four stages in four cycles
// Overview of operation
// [RQ1] Record path when select low, an ADC on
// [RQ2] Playback path when select high or ADCs off
// [RQ3] Serial output held low while select high
// [RQ4] Loop-through sets both path switches high
// [RQ5] Host clears enables before changing modes
// [RQ6] Two high-pass stages share one coefficient pair
// [RQ7] Each high-pass stage has its own enable
// [RQ8] Disabled high-pass passes samples unchanged
// [RQ9] High-pass uses difference numerator, B feedback
// [RQ10] Host loads high-pass coefficients while disabled
// [RQ11] Host keeps high-pass cutoff above minimum
// [RQ12] Low-pass uses sum numerator, own enable
// [RQ13] Host loads low-pass coefficients while disabled
// [RQ14] Host keeps low-pass cutoff above minimum
// [RQ15] Separation stage type bit picks high/low-pass
// [RQ16] Separation stage has enable, bypass unity
// [RQ17] Separation stage uses A gain, B feedback
// [RQ18] Host loads separation coefficients while disabled
// [RQ19] Mic supply driven when enabled, else floating
// [RQ20] Coefficients signed, scaled by two to thirteen
// [RQ21] Fixed order, one result per channel per tick
// [RQ22] Saturating arithmetic; disabled stage state cleared
`timescale 1ns/1ps
module apsf_chain #(
    parameter int FS_DIV = apsf_pkg::FS_DIV,
    parameter int DEPTH = apsf_pkg::FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic left_adc_power,
    input wire logic right_adc_power,
    input wire logic dac_power,
    input wire logic chain_to_playback_select,
    input wire logic loop_enable,
    input wire logic mic_supply_enable,
    input wire logic highpass_stage1_enable,
    input wire logic highpass_stage2_enable,
    input wire logic lowpass_enable,
    input wire logic separation_filter_enable,
    input wire logic separation_type_select,
    input wire logic [13:0] highpass_coef_a,
    input wire logic [13:0] highpass_coef_b,
    input wire logic [13:0] lowpass_coef_a,
    input wire logic [13:0] lowpass_coef_b,
    input wire logic [13:0] separation_coef_a,
    input wire logic [13:0] separation_coef_b,
    input wire logic adc_valid,
    input wire logic [15:0] adc_left,
    input wire logic [15:0] adc_right,
    output logic adc_ready,
    input wire logic play_valid,
    input wire logic [15:0] play_left,
    input wire logic [15:0] play_right,
    output logic play_ready,
    output logic serial_out_valid,
    output logic [15:0] serial_out_left,
    output logic [15:0] serial_out_right,
    output logic dac_valid,
    output logic [15:0] dac_left,
    output logic [15:0] dac_right,
    output logic record_path_switch,
    output logic playback_path_switch,
    output logic mic_supply_out,
    output logic mic_supply_oe
);
    localparam int SW = apsf_pkg::SAMPLE_W;
    localparam int NS = apsf_pkg::NUM_STAGES;
    localparam int DIV_W = $clog2(FS_DIV);

    // ********
    // Declarations
    // ********
    logic [DIV_W-1:0] div_cnt;
    logic fs_tick, tick_pending, adc_any, stage_sum;
    logic playback_mode, loop_mode, next_sw1, next_sw2;
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [apsf_pkg::PAIR_W-1:0] fifo_in_data;
    logic [apsf_pkg::PAIR_W-1:0] fifo_out_data;
    apsf_pkg::apsf_state_t state;
    logic [1:0] stage;
    logic [NS-1:0] stage_en;
    logic signed [13:0] coef_a, coef_b;
    logic signed [SW-1:0] cur [2];

    // First-order section with saturation to the sample width
    function automatic logic signed [15:0] apsf_section(
        input logic signed [15:0] x,
        input logic signed [15:0] xp,
        input logic signed [15:0] yp,
        input logic signed [13:0] a,
        input logic signed [13:0] b,
        input logic sum_form
    );
        logic signed [16:0] d;
        logic signed [31:0] acc;
        logic signed [18:0] sh;
        d = sum_form ? ({x[15], x} + {xp[15], xp})
                     : ({x[15], x} - {xp[15], xp});
        acc = (32'(a) * 32'(d)) - (32'(b) * 32'(yp));
        sh = acc[31:apsf_pkg::COEF_FRAC];
        // Clamp instead of wrapping to avoid loud overflow clicks
        if (sh > $signed({3'b000, apsf_pkg::SAMPLE_MAX})) begin
            apsf_section = apsf_pkg::SAMPLE_MAX; // see [RQ22]
        end else if (sh < $signed({3'b111, apsf_pkg::SAMPLE_MIN})) begin
            apsf_section = apsf_pkg::SAMPLE_MIN; // see [RQ22]
        end else begin
            apsf_section = sh[15:0];
        end
    endfunction

    // ********
    // Mode decode and path switches
    // ********
    assign adc_any = left_adc_power | right_adc_power;
    // Playback wins whenever select is high or no ADC is on
    assign playback_mode = chain_to_playback_select | ~adc_any; // see [RQ2]
    assign loop_mode = loop_enable & dac_power & adc_any
                     & ~chain_to_playback_select; // see [RQ4]
    assign next_sw1 = ~playback_mode; // see [RQ1]
    assign next_sw2 = playback_mode | loop_mode; // see [RQ4]

    // Switches are flops; mode changes take effect one cycle later
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            record_path_switch <= 1'b0;
            playback_path_switch <= 1'b1;
        end else begin
            record_path_switch <= next_sw1;
            playback_path_switch <= next_sw2;
        end
    end

    // Mic supply pin; oe low leaves it floating
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mic_supply_out <= 1'b0;
            mic_supply_oe <= 1'b0;
        end else begin
            mic_supply_out <= mic_supply_enable; // see [RQ19]
            mic_supply_oe <= mic_supply_enable; // see [RQ19]
        end
    end

    // ********
    // Sample-rate divider
    // ********
    assign fs_tick = (div_cnt == DIV_W'(FS_DIV - 1));
    // Free-running count of clocks per sample period
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            div_cnt <= '0;
        end else if (fs_tick) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    // ********
    // Source mux into the FIFO
    // ********
    // Converter data feeds the chain on record and loop, host otherwise
    assign fifo_in_valid = record_path_switch ? adc_valid : play_valid;
    assign fifo_in_data = record_path_switch ? {adc_left, adc_right}
                                             : {play_left, play_right};
    assign adc_ready = record_path_switch & fifo_in_ready;
    assign play_ready = ~record_path_switch & fifo_in_ready;

    apsf_fifo #(
        .WIDTH(apsf_pkg::PAIR_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clock(clock),
        .nrst(nrst),
        .in_valid(fifo_in_valid),
        .in_data(fifo_in_data),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(fifo_pop)
    );

    // ********
    // Sequencer: one pair per tick, four stages in order
    // ********
    // A tick stays pending until a pair is available to consume
    assign fifo_pop = (state == apsf_pkg::APSF_IDLE) & tick_pending
                    & fifo_out_valid; // see [RQ21]
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tick_pending <= 1'b0;
        end else if (fs_tick) begin
            tick_pending <= 1'b1;
        end else if (fifo_pop) begin
            tick_pending <= 1'b0;
        end
    end

    // Stage walk: high-pass 1, high-pass 2, low-pass, separation
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= apsf_pkg::APSF_IDLE;
            stage <= 2'h0;
        end else begin
            case (state)
                apsf_pkg::APSF_IDLE: begin
                    if (fifo_pop) begin
                        state <= apsf_pkg::APSF_RUN;
                        stage <= 2'h0;
                    end
                end
                apsf_pkg::APSF_RUN: begin
                    stage <= stage + 2'h1; // see [RQ21]
                    if (stage == 2'(NS - 1)) begin
                        state <= apsf_pkg::APSF_EMIT;
                    end
                end
                apsf_pkg::APSF_EMIT: begin
                    state <= apsf_pkg::APSF_IDLE;
                end
                default: begin
                    state <= apsf_pkg::APSF_IDLE;
                end
            endcase
        end
    end

    // ********
    // Per-stage enables and coefficients
    // ********
    assign stage_en[apsf_pkg::STG_HP1] = highpass_stage1_enable; // see [RQ7]
    assign stage_en[apsf_pkg::STG_HP2] = highpass_stage2_enable; // see [RQ7]
    assign stage_en[apsf_pkg::STG_LP] = lowpass_enable; // see [RQ12]
    assign stage_en[apsf_pkg::STG_SEP] = separation_filter_enable; // see [RQ16]
    // Coefficient words are taken as signed 1.13 values
    always_comb begin
        case (stage)
            2'(apsf_pkg::STG_LP): begin
                coef_a = $signed(lowpass_coef_a);
                coef_b = $signed(lowpass_coef_b);
                stage_sum = 1'b1; // see [RQ12]
            end
            2'(apsf_pkg::STG_SEP): begin
                coef_a = $signed(separation_coef_a); // see [RQ17]
                coef_b = $signed(separation_coef_b); // see [RQ17]
                stage_sum = separation_type_select; // see [RQ15]
            end
            default: begin
                coef_a = $signed(highpass_coef_a); // see [RQ6] [RQ20]
                coef_b = $signed(highpass_coef_b); // see [RQ6] [RQ9]
                stage_sum = 1'b0; // see [RQ9]
            end
        endcase
    end

    // ********
    // Datapath, one copy per channel (0 = left, 1 = right)
    // ********
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        logic signed [SW-1:0] x_prev [NS];
        logic signed [SW-1:0] y_prev [NS];
        logic signed [SW-1:0] y_new;
        assign y_new = apsf_section(cur[ch], x_prev[stage], y_prev[stage],
                                    coef_a, coef_b, stage_sum);
        // Working sample: loaded from the FIFO, updated per stage
        always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
                cur[ch] <= apsf_pkg::SAMPLE_ZERO;
            end else if (fifo_pop) begin
                cur[ch] <= (ch == 0) ? fifo_out_data[2*SW-1:SW]
                                     : fifo_out_data[SW-1:0];
            end else if (state == apsf_pkg::APSF_RUN &&
                         stage_en[stage]) begin
                cur[ch] <= y_new; // see [RQ9] [RQ12] [RQ17]
            end
        end

        // History per stage; bypass leaves the sample as is
        for (genvar s = 0; s < NS; s++) begin : g_hist
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    x_prev[s] <= apsf_pkg::SAMPLE_ZERO;
                    y_prev[s] <= apsf_pkg::SAMPLE_ZERO;
                end else if (!stage_en[s]) begin
                    // Cleared so re-enabling starts from silence
                    x_prev[s] <= apsf_pkg::SAMPLE_ZERO; // see [RQ22] [RQ8]
                    y_prev[s] <= apsf_pkg::SAMPLE_ZERO; // see [RQ22]
                end else if (state == apsf_pkg::APSF_RUN &&
                             stage == 2'(s)) begin
                    x_prev[s] <= cur[ch];
                    y_prev[s] <= y_new;
                end
            end
        end
    end

    // ********
    // Result steering to serial output and DAC
    // ********
    // Serial output is forced low whenever select is high
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            serial_out_valid <= 1'b0;
            serial_out_left <= apsf_pkg::SAMPLE_ZERO;
            serial_out_right <= apsf_pkg::SAMPLE_ZERO;
        end else if (chain_to_playback_select) begin
            serial_out_valid <= fs_tick; // see [RQ3]
            serial_out_left <= apsf_pkg::SAMPLE_ZERO; // see [RQ3]
            serial_out_right <= apsf_pkg::SAMPLE_ZERO; // see [RQ3]
        end else begin
            serial_out_valid <= (state == apsf_pkg::APSF_EMIT)
                              & record_path_switch; // see [RQ1]
            if (state == apsf_pkg::APSF_EMIT && record_path_switch) begin
                serial_out_left <= cur[0];
                serial_out_right <= cur[1];
            end
        end
    end

    // DAC gets chain output on playback and loop-through
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            dac_valid <= 1'b0;
            dac_left <= apsf_pkg::SAMPLE_ZERO;
            dac_right <= apsf_pkg::SAMPLE_ZERO;
        end else begin
            dac_valid <= (state == apsf_pkg::APSF_EMIT)
                       & playback_path_switch; // see [RQ2] [RQ4]
            if (state == apsf_pkg::APSF_EMIT && playback_path_switch) begin
                dac_left <= cur[0];
                dac_right <= cur[1];
            end
        end
    end
endmodule

// ===== tb/apsf_assertions.sv
// Purpose: Port-level checks of the path select and filter chain
// Assumes: One clock domain, nrst asynchronous and active low
// Notes: Bound to every chain instance; sees only its ports
`timescale 1ns/1ps
module apsf_assertions (
    input wire logic clock,
    input wire logic nrst,
    input wire logic left_adc_power,
    input wire logic right_adc_power,
    input wire logic dac_power,
    input wire logic chain_to_playback_select,
    input wire logic loop_enable,
    input wire logic mic_supply_enable,
    input wire logic adc_ready,
    input wire logic play_ready,
    input wire logic serial_out_valid,
    input wire logic [15:0] serial_out_left,
    input wire logic [15:0] serial_out_right,
    input wire logic dac_valid,
    input wire logic record_path_switch,
    input wire logic playback_path_switch,
    input wire logic mic_supply_out,
    input wire logic mic_supply_oe
);
    localparam int PIPE = 6;
    logic rec_mode;
    int gap;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    // Recording wants select low and at least one converter powered
    assign rec_mode = !chain_to_playback_select &&
        (left_adc_power || right_adc_power);

    // Cycles since the last playback result, saturating at PIPE
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            gap <= PIPE;
        end else if (dac_valid) begin
            gap <= 1;
        end else if (gap < PIPE) begin
            gap <= gap + 1;
        end
    end

    sequence sel_held;
        chain_to_playback_select [*8];
    endsequence
    sequence sel_low_held;
        !chain_to_playback_select [*3];
    endsequence

    record_mode_a: assert property (rec_mode && !loop_enable |=>
        record_path_switch && !playback_path_switch)
        else $error("record mode switches wrong");
    loop_mode_a: assert property (rec_mode && loop_enable && dac_power
        |=> record_path_switch && playback_path_switch)
        else $error("loop mode switches wrong");
    play_mode_a: assert property (!rec_mode |=>
        !record_path_switch && playback_path_switch)
        else $error("playback mode switches wrong");
    source_excl_a: assert property (adc_ready |->
        record_path_switch && !play_ready)
        else $error("both sources accepted");
    serial_quiet_a: assert property (sel_held ##0 serial_out_valid |->
        serial_out_left == 16'h0000 && serial_out_right == 16'h0000)
        else $error("serial output not low in playback");
    serial_gate_a: assert property (sel_low_held ##0 serial_out_valid
        |-> record_path_switch)
        else $error("serial result outside recording");
    dac_gate_a: assert property (dac_valid |-> playback_path_switch)
        else $error("playback result without playback path");
    mic_drive_a: assert property (mic_supply_enable |=>
        mic_supply_oe && mic_supply_out)
        else $error("mic supply not driven");
    mic_float_a: assert property (!mic_supply_enable |=> !mic_supply_oe)
        else $error("mic supply driven while off");
    tick_space_a: assert property (dac_valid |-> gap >= PIPE)
        else $error("playback results too close");
endmodule

bind apsf_chain apsf_assertions u_chk (.*);

// ===== tb/apsf_src_model.sv
// Purpose: Converter or serial-port side source of sample pairs
// Assumes: Pairs packed left in the upper half
// Notes: gap sets idle cycles after each take, to model a slow source
`timescale 1ns/1ps
module apsf_src_model (
    input wire logic clock,
    input wire logic nrst,
    output logic valid,
    output logic [31:0] data,
    input wire logic ready
);
    logic [31:0] q[$];
    int gap = 0;
    int wait_cnt;

    // Pair held whole until taken; released data inverted, never stale
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            valid <= 1'b0;
            data <= 32'h0000_0000;
            wait_cnt <= 0;
        end else if (valid && ready) begin
            valid <= 1'b0;
            data <= ~data;
            wait_cnt <= gap;
        end else if (!valid && wait_cnt > 0) begin
            wait_cnt <= wait_cnt - 1;
        end else if (!valid && q.size() > 0) begin
            data <= q.pop_front();
            valid <= 1'b1;
        end
    end
endmodule

// ===== tb/audio_path_select_filter_chain_test.sv
// Purpose: Self-checking bench for the path select and filter chain
// Assumes: FS_DIV shortened to 8 so ticks come quickly
// Notes: Expected samples come from a bench-side filter reference
`timescale 1ns/1ps
module audio_path_select_filter_chain_test;
    logic clock = 1'b0, nrst = 1'b0;
    logic left_adc_power, right_adc_power, dac_power;
    logic chain_to_playback_select, loop_enable, mic_supply_enable;
    logic highpass_stage1_enable, highpass_stage2_enable;
    logic lowpass_enable, separation_filter_enable, separation_type_select;
    logic [13:0] highpass_coef_a, highpass_coef_b, lowpass_coef_a;
    logic [13:0] lowpass_coef_b, separation_coef_a, separation_coef_b;
    logic adc_valid, adc_ready, play_valid, play_ready, serial_out_valid;
    logic dac_valid, record_path_switch, playback_path_switch;
    logic mic_supply_out, mic_supply_oe, full_seen = 1'b0;
    wire [15:0] adc_left, adc_right, play_left, play_right;
    logic [15:0] serial_out_left, serial_out_right, dac_left, dac_right;
    logic [3:0] en;
    logic [31:0] sq[$], dq[$], eq[$], keep[$];
    logic signed [15:0] xh[2][4], yh[2][4];
    int n_errors = 0, compares = 0, cyc = 0;
    logic [6:0] modes[9] = '{7'h62, 7'h32, 7'h11, 7'h79, 7'h77, 7'h57,
        7'h37, 7'h0d, 7'h66};
    logic [4:0] cfg[7] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h08, 5'h18, 5'h1f};
    logic [31:0] stim[4] = '{32'h7530_8ad0, 32'h8ad0_7530, 32'h0100_ff00,
        32'h7fff_8000};

    assign {separation_filter_enable, lowpass_enable} = en[3:2];
    assign {highpass_stage2_enable, highpass_stage1_enable} = en[1:0];
    apsf_chain #(.FS_DIV(8)) DUT (.*);
    apsf_src_model u_adc (.clock(clock), .nrst(nrst), .valid(adc_valid),
        .data({adc_left, adc_right}), .ready(adc_ready));
    apsf_src_model u_play (.clock(clock), .nrst(nrst), .valid(play_valid),
        .data({play_left, play_right}), .ready(play_ready));

    always #2.5 clock = ~clock;

    // Capture results, watch for refusal, cut a hang short
    always @(posedge clock) begin
        cyc++;
        if (serial_out_valid) sq.push_back({serial_out_left, serial_out_right});
        if (dac_valid) dq.push_back({dac_left, dac_right});
        if (adc_valid && !adc_ready && record_path_switch) full_seen = 1'b1;
        if (cyc == 20000) begin
            n_errors++;
            $display("[ERR] %0t timeout", $time);
            test_done();
        end
    end

    task automatic test_done();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk_pair(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t pair %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t bit %b expected %b", $time, got, exp);
        end
    endtask

    // Mode order {left, right, dac, select, loop}; enables cleared first
    task automatic set_mode(input logic [4:0] m);
        @(posedge clock);
        en <= 4'h0;
        @(posedge clock);
        {left_adc_power, right_adc_power, dac_power} <= m[4:2];
        {chain_to_playback_select, loop_enable} <= m[1:0];
        repeat (3) @(posedge clock);
        foreach (xh[c, s]) begin
            xh[c][s] = 16'sh0000;
            yh[c][s] = 16'sh0000;
        end
        sq.delete();
        dq.delete();
    endtask

    // Reference stage: floor shift, then 16-bit saturation
    function automatic logic signed [15:0] stg(input logic signed [15:0] x,
        input logic signed [15:0] xp, input logic signed [15:0] yp,
        input logic signed [13:0] a, input logic signed [13:0] b,
        input bit sum);
        longint acc;
        acc = longint'(a) * (sum ? longint'(x) + xp : longint'(x) - xp);
        acc = (acc - longint'(b) * yp) >>> 13;
        if (acc > 32767) return 16'sh7fff;
        if (acc < -32768) return 16'sh8000;
        return acc[15:0];
    endfunction

    // Queue one pair at a source and its expected chain result
    task automatic feed(input logic [31:0] w, input bit rec);
        logic signed [15:0] v, y;
        logic [31:0] e;
        for (int c = 0; c < 2; c++) begin
            v = c ? w[15:0] : w[31:16];
            for (int s = 0; s < 4; s++) if (en[s]) begin
                y = stg(v, xh[c][s], yh[c][s],
                    s < 2 ? highpass_coef_a : s == 2 ? lowpass_coef_a :
                    separation_coef_a, s < 2 ? highpass_coef_b :
                    s == 2 ? lowpass_coef_b : separation_coef_b,
                    s == 2 || (s == 3 && separation_type_select));
                xh[c][s] = v;
                yh[c][s] = y;
                v = y;
            end
            if (c) e[15:0] = v;
            else e[31:16] = v;
        end
        eq.push_back(e);
        if (rec) u_adc.q.push_back(w);
        else u_play.q.push_back(w);
    endtask

    // Wait for all expected results, then compare them in order
    task automatic drain(input bit to_dac);
        for (int k = 0; k < 2000; k++) begin
            if ((to_dac ? dq.size() : sq.size()) >= eq.size()) break;
            @(posedge clock);
        end
        while (eq.size() > 0)
            chk_pair(to_dac ? dq.pop_front() : sq.pop_front(),
                eq.pop_front());
    endtask

    initial begin
        {left_adc_power, right_adc_power, dac_power, loop_enable} = 4'h0;
        {chain_to_playback_select, mic_supply_enable} = 2'h0;
        {en, separation_type_select} = 5'h00;
        {highpass_coef_a, highpass_coef_b} = {14'h0f00, 14'h3e00};
        {lowpass_coef_a, lowpass_coef_b} = {14'h0800, 14'h0400};
        {separation_coef_a, separation_coef_b} = {14'h1000, 14'h3f00};
        repeat (20) @(posedge clock);
        chk_bit(playback_path_switch, 1'b1);
        chk_bit(mic_supply_oe, 1'b0);
        nrst <= 1'b1;
        $display("reset test done");
        foreach (modes[i]) begin
            set_mode(modes[i][6:2]);
            chk_bit(record_path_switch, modes[i][1]);
            chk_bit(playback_path_switch, modes[i][0]);
        end
        $display("mode table test done");
        mic_supply_enable <= 1'b1;
        repeat (2) @(posedge clock);
        chk_bit(mic_supply_out & mic_supply_oe, 1'b1);
        mic_supply_enable <= 1'b0;
        repeat (2) @(posedge clock);
        chk_bit(mic_supply_oe, 1'b0);
        $display("mic supply test done");
        // Coefs fixed while enables low
        foreach (cfg[i]) begin
            set_mode(5'h18);
            {separation_type_select, en} <= cfg[i];
            repeat (2) @(posedge clock);
            foreach (stim[j]) feed(stim[j], 1'b1);
            drain(1'b0);
        end
        $display("record filter test done");
        set_mode(5'h18);
        for (int i = 0; i < 24; i++) feed({i[15:0], ~i[15:0]}, 1'b1);
        drain(1'b0);
        chk_bit(full_seen, 1'b1);
        $display("fifo test done");
        set_mode(5'h1e);
        u_play.gap = 3;
        foreach (stim[j]) feed(stim[j], 1'b0);
        drain(1'b1);
        chk_bit(adc_ready, 1'b0);
        chk_bit(sq.size() > 0, 1'b1);
        while (sq.size() > 0) chk_pair(sq.pop_front(), 32'h0000_0000);
        $display("playback test done");
        set_mode(5'h15);
        foreach (stim[j]) feed(stim[j], 1'b1);
        keep = eq;
        drain(1'b0);
        eq = keep;
        drain(1'b1);
        $display("loop test done");
        test_done();
    end
endmodule
